//--- hw/ocs_sync.sv
// operation-complete synchronizer for *OPC, *OPC? and *WAI
`timescale 1ns/1ps
`include "ocs_regs.svh"
module ocs_sync import ocs_pkg::*; #(
	parameter int unsigned SETTLE_CYC = `OCS_SETTLE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// command from the parser
	input wire logic cmdValid,
	input wire logic [1:0] cmdCode,
	input wire logic prevDone,
	// measurement engines
	input wire logic [7:0] measDisplayed,
	input wire logic [7:0] measOn,
	input wire logic [7:0] measDone,
	output logic measReq,
	// status registers from the status block
	input wire logic [7:0] eventEnable,
	input wire logic [7:0] srqEnable,
	input wire logic esrClear,
	input wire logic queueRead,
	input wire logic abort,
	// results
	output logic opcEvent,
	output logic mav,
	output logic srq,
	output logic qValid,
	output logic [7:0] qData,
	output logic holdOff,
	output logic cmdStall,
	output logic busy
);
	ocs_state_s_t cur;
	ocs_state_s_t next_cur;
	logic [7:0] active;
	logic allDone;
	logic timerDone;
	logic takeCmd;
	logic finished;

	// command code decode, shared by the stall and hold-off set-up
	function automatic logic isCmd(input logic [1:0] code, input ocs_cmd_t which);
		return ocs_cmd_t'(code) == which;
	endfunction

	// a measurement takes part only when it is on screen and switched on
	function automatic logic [7:0] activeMask(input logic [7:0] shown, input logic [7:0] on);
		return shown & on;
	endfunction

	// every active measurement has reported done at least once
	function automatic logic allReported(input logic [7:0] seen, input logic [7:0] act);
		return &(seen | ~act);
	endfunction

	// satisfied only with timer, measurements and earlier commands all done
	function automatic logic cmdSatisfied(input logic tmr, input logic meas, input logic prev);
		return tmr && meas && prev;
	endfunction

	// service request from the summary bits, MAV masked by the service enable, OPC by both enables
	function automatic logic srqLevel(input logic mavBit, input logic opcBit,
		input logic [7:0] ese, input logic [7:0] sre);
		return (mavBit && sre[`OCS_STB_MAV_BIT])
			|| (opcBit && ese[`OCS_ESR_OPC_BIT] && sre[`OCS_STB_ESB_BIT]);
	endfunction

	assign active = activeMask(measDisplayed, measOn);
	// off or unavailable measurements never report, so they are left out of the wait
	assign allDone = allReported(cur.doneSeen, active);
	assign timerDone = (cur.timer == 32'h0000_0000);
	// an unread answer refuses new commands until the controller takes it
	assign takeCmd = (cur.state == OCS_IDLE) && cmdValid && !cur.qValid;
	assign finished = cmdSatisfied(timerDone, allDone, prevDone);

	always_comb begin
		next_cur = cur;
		case (cur.state)
			OCS_IDLE: begin
				next_cur.measReq = 1'b0;
				if (takeCmd) begin
					next_cur.cmd = ocs_cmd_t'(cmdCode);
					next_cur.timer = SETTLE_CYC - 1;
					next_cur.doneSeen = 8'h00;
					next_cur.measReq = 1'b1;
					next_cur.busy = 1'b1;
					next_cur.state = OCS_WAIT;
					if (isCmd(cmdCode, OCS_CMD_WAI)) begin
						next_cur.cmdStall = 1'b1;
					end
					if (isCmd(cmdCode, OCS_CMD_QRY)) begin
						next_cur.holdOff = 1'b1;
					end
				end
			end
			OCS_WAIT: begin
				if (!timerDone) begin
					next_cur.timer = cur.timer - 32'h0000_0001;
				end
				next_cur.doneSeen = cur.doneSeen | (measDone & active);
				if (finished) begin
					next_cur.state = OCS_DONE;
				end
			end
			OCS_DONE: begin
				next_cur.state = OCS_IDLE;
				next_cur.measReq = 1'b0;
				next_cur.busy = 1'b0;
				next_cur.cmdStall = 1'b0;
				case (cur.cmd)
					OCS_CMD_OPC: next_cur.opcEvent = 1'b1;
					OCS_CMD_QRY: begin
						next_cur.qValid = 1'b1;
						next_cur.qData = `OCS_ASCII_ONE;
						next_cur.mav = 1'b1;
						next_cur.holdOff = 1'b0;
					end
					default: begin
					end
				endcase
			end
			default: next_cur.state = OCS_IDLE;
		endcase
		// set wins over clear
		if (esrClear && !(cur.state == OCS_DONE && cur.cmd == OCS_CMD_OPC)) begin
			next_cur.opcEvent = 1'b0;
		end
		if (queueRead && cur.qValid) begin
			next_cur.qValid = 1'b0;
			next_cur.mav = 1'b0;
		end
		if (abort) begin
			next_cur.state = OCS_IDLE;
			next_cur.measReq = 1'b0;
			next_cur.busy = 1'b0;
			next_cur.cmdStall = 1'b0;
			next_cur.holdOff = 1'b0;
		end
		// registered from the next status so srq leaves the flop with mav and opc
		next_cur.srq = srqLevel(next_cur.mav, next_cur.opcEvent,
			eventEnable, srqEnable);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cur <= '{state: OCS_IDLE, cmd: OCS_CMD_OPC, default: '0};
		end else begin
			cur <= next_cur;
		end
	end

	assign measReq = cur.measReq;
	assign opcEvent = cur.opcEvent;
	assign mav = cur.mav;
	assign srq = cur.srq;
	assign qValid = cur.qValid;
	assign qData = cur.qData;
	assign holdOff = cur.holdOff;
	assign cmdStall = cur.cmdStall;
	assign busy = cur.busy;

	// counter of cycles spent in the wait state, for checks
	logic [31:0] waitCnt;
	always_ff @(posedge clk) begin
		if (!rstn || cur.state != OCS_WAIT) begin
			waitCnt <= 32'h0000_0000;
		end else begin
			waitCnt <= waitCnt + 32'h0000_0001;
		end
	end

	AST_SETTLE_MIN: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && next_cur.state == OCS_DONE) |-> waitCnt >= SETTLE_CYC - 1)
		else $error("completion before settling time");
	AST_OPC_SET: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_DONE && cur.cmd == OCS_CMD_OPC && !abort) |=> opcEvent)
		else $error("opc bit not set");
	AST_ALL_DONE: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && !(allDone && timerDone)) |=> cur.state != OCS_DONE)
		else $error("completion without all done");
	AST_INACTIVE_BLOCK: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && (active & ~cur.doneSeen & ~measDone) != 8'h00)
		|=> cur.state != OCS_DONE)
		else $error("pending measurement ignored");
	AST_QUERY_CHAR: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_DONE && cur.cmd == OCS_CMD_QRY && !abort)
		|=> qValid && qData == `OCS_ASCII_ONE)
		else $error("query answer missing");
	AST_MAV_WITH_Q: assert property (@(posedge clk) disable iff (!rstn)
		$rose(qValid) |-> mav)
		else $error("mav not set with answer");
	AST_HOLDOFF: assert property (@(posedge clk) disable iff (!rstn)
		(holdOff && cur.state == OCS_WAIT && !abort) |=> holdOff || qValid)
		else $error("holdoff dropped early");
	AST_SRQ_MAV: assert property (@(posedge clk) disable iff (!rstn)
		(mav && srqEnable[`OCS_STB_MAV_BIT]) |-> ##[0:1] srq)
		else $error("no service request on mav");
	AST_SRQ_OPC: assert property (@(posedge clk) disable iff (!rstn)
		(opcEvent && eventEnable[0] && srqEnable[5]) |-> ##[0:1] srq)
		else $error("no service request on opc");
	AST_WAI_STALL: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && cur.cmd == OCS_CMD_WAI) |-> cmdStall)
		else $error("wait does not stall");
	AST_ACTIVE: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && !(measDisplayed[0] && measOn[0]))
		|=> cur.doneSeen[0] == 1'b0 || $past(cur.doneSeen[0]))
		else $error("inactive measurement counted");

	// command acceptance
	AST_TAKE: assert property (@(posedge clk) disable iff (!rstn)
		(takeCmd && !abort)
		|=> busy && measReq)
		else $error("command not taken");
	AST_TIMER_LOAD: assert property (@(posedge clk) disable iff (!rstn)
		(takeCmd && !abort)
		|=> cur.timer == SETTLE_CYC - 1)
		else $error("settling timer not loaded");
	AST_WAIT_IGNORE: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && cmdValid)
		|=> cur.cmd == $past(cur.cmd))
		else $error("command taken while waiting");
	AST_QVALID_REFUSE: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_IDLE && qValid && cmdValid)
		|=> cur.state == OCS_IDLE)
		else $error("command taken over unread answer");
	AST_BUSY_LEVEL: assert property (@(posedge clk) disable iff (!rstn)
		busy
		|-> cur.state != OCS_IDLE)
		else $error("busy while idle");

	// settling and completion
	AST_TIMER_STEP: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && !timerDone && !abort)
		|=> cur.timer == $past(cur.timer) - 32'h0000_0001)
		else $error("settling timer does not count");
	AST_MEASREQ: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT)
		|-> measReq)
		else $error("done request missing while waiting");
	AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_IDLE)
		|-> !measReq)
		else $error("done request while idle");
	AST_PREV_WAIT: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && !prevDone)
		|=> cur.state != OCS_DONE)
		else $error("completion before earlier commands");
	AST_PENDING_BUSY: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && !allDone && !abort)
		|=> busy)
		else $error("pending wait released");
	AST_ABORT: assert property (@(posedge clk) disable iff (!rstn)
		abort
		|=> !busy && !cmdStall && !holdOff)
		else $error("abort does not release");
	AST_STALL_WAI_ONLY: assert property (@(posedge clk) disable iff (!rstn)
		cmdStall
		|-> cur.state != OCS_IDLE && cur.cmd == OCS_CMD_WAI)
		else $error("stall without wait command");

	// answer and status
	AST_QRY_HOLD: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_WAIT && cur.cmd == OCS_CMD_QRY)
		|-> holdOff)
		else $error("query pending without holdoff");
	AST_HOLD_ONLY_QRY: assert property (@(posedge clk) disable iff (!rstn)
		holdOff
		|-> cur.state != OCS_IDLE && cur.cmd == OCS_CMD_QRY)
		else $error("holdoff without pending query");
	AST_MAV_SET: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == OCS_DONE && cur.cmd == OCS_CMD_QRY && !abort)
		|=> mav)
		else $error("mav not set on answer");
	AST_QDATA: assert property (@(posedge clk) disable iff (!rstn)
		qValid
		|-> qData == `OCS_ASCII_ONE)
		else $error("wrong answer byte");
	AST_CLEAR_Q: assert property (@(posedge clk) disable iff (!rstn)
		(queueRead && qValid)
		|=> !qValid && !mav)
		else $error("answer not taken on read");
	AST_OPC_HOLD: assert property (@(posedge clk) disable iff (!rstn)
		(opcEvent && !esrClear)
		|=> opcEvent)
		else $error("opc bit lost before clear");
	AST_NO_SRQ: assert property (@(posedge clk) disable iff (!rstn)
		(!mav && !opcEvent)
		|-> !srq)
		else $error("service request without cause");

	COV_OPC: cover property (@(posedge clk) disable iff (!rstn) $rose(opcEvent));
	COV_QRY: cover property (@(posedge clk) disable iff (!rstn) $rose(qValid));
	COV_WAI: cover property (@(posedge clk) disable iff (!rstn) $fell(cmdStall));
	COV_SRQ: cover property (@(posedge clk) disable iff (!rstn) $rose(srq));
	COV_ABORT: cover property (@(posedge clk) disable iff (!rstn) cur.state == OCS_WAIT && abort);
endmodule

//--- shared/ocs_pkg.sv
// types of the operation-complete synchronizer
package ocs_pkg;
	typedef enum logic [1:0] {
		OCS_CMD_OPC = 2'h0,
		OCS_CMD_QRY = 2'h1,
		OCS_CMD_WAI = 2'h2
	} ocs_cmd_t;
	typedef enum logic [1:0] {
		OCS_IDLE = 2'b00,
		OCS_WAIT = 2'b01,
		OCS_DONE = 2'b10
	} ocs_state_t;
	typedef struct packed {
		ocs_state_t state;
		ocs_cmd_t cmd;
		logic [31:0] timer;
		logic [7:0] doneSeen;
		logic opcEvent;
		logic mav;
		logic srq;
		logic qValid;
		logic [7:0] qData;
		logic holdOff;
		logic cmdStall;
		logic measReq;
		logic busy;
	} ocs_state_s_t;
endpackage

//--- shared/ocs_regs.svh
// constants of the operation-complete synchronizer
// Function
// - after the completion command, set event bit 0 once all work is finished
// - any of the three sync commands starts a one-second settling timer
// - ask active measurements for done; satisfied when all done and timer expired
// - a measurement that is off or unavailable is left out and does not block completion
// - for the completion query, append ASCII 1 to the output queue when finished
// - when the completion character enters the queue, set the MAV bit
// - hold the query answer back until all earlier commands have completed
// - while the answer is pending, hold off the bus read handshake
// - with service-enable bit 4 set, request service when MAV becomes 1
// - with event-enable bit 0 and service-enable bit 5, request service on OPC
// - on wait-to-continue, stall later commands until earlier ones have completed
// - a measurement is active only when displayed and switched on
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH
`define OCS_CLK_HZ 50000000
`define OCS_SETTLE_MS 1000
`define OCS_SETTLE_CYC ((`OCS_CLK_HZ / 1000) * `OCS_SETTLE_MS)
`define OCS_MEAS_N 8
`define OCS_ESR_OPC_BIT 0
`define OCS_STB_MAV_BIT 4
`define OCS_STB_ESB_BIT 5
`define OCS_ASCII_ONE 8'h31
`endif

//--- tb/ocs_ctrl_model.sv
// bus controller model that reads the pending answer byte
`timescale 1ns/1ps
module ocs_ctrl_model (
	// clock
	input wire logic clk,
	// answer side
	input wire logic rdEn,
	input wire logic qValid,
	input wire logic [7:0] qData,
	output logic queueRead,
	output logic [7:0] got
);
	initial queueRead = 1'b0;
	initial got = 8'h00;
	// the read waits until the answer byte is there
	always @(posedge clk) begin
		queueRead <= rdEn && qValid && !queueRead;
		if (rdEn && qValid) begin
			got <= qData;
		end
	end
endmodule

//--- tb/ocs_sync_tb.sv
// testbench of the operation-complete synchronizer
`timescale 1ns/1ps
module ocs_sync_tb;
	localparam int SC = 20;
	logic clk = 0, rstn = 0, cmdValid = 0, prevDone = 1, esrClear = 0, abort = 0, rdEn = 0;
	logic [1:0] cmdCode = 2'h0;
	logic [7:0] measDisplayed = 8'h00, measOn = 8'h00, measDone = 8'h00;
	logic [7:0] eventEnable = 8'h00, srqEnable = 8'h00, qData, got;
	logic measReq, opcEvent, mav, srq, qValid, holdOff, cmdStall, busy, queueRead;
	int n_errors = 0, check_count = 0, k;
	ocs_sync #(.SETTLE_CYC(SC)) u_ocs_sync (.clk(clk), .rstn(rstn), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .prevDone(prevDone), .measDisplayed(measDisplayed), .measOn(measOn),
		.measDone(measDone), .measReq(measReq), .eventEnable(eventEnable), .srqEnable(srqEnable),
		.esrClear(esrClear), .queueRead(queueRead), .abort(abort), .opcEvent(opcEvent),
		.mav(mav), .srq(srq), .qValid(qValid), .qData(qData), .holdOff(holdOff),
		.cmdStall(cmdStall), .busy(busy));
	ocs_ctrl_model u_ocs_ctrl_model (.clk(clk), .rdEn(rdEn), .qValid(qValid), .qData(qData),
		.queueRead(queueRead), .got(got));
	initial forever #10 clk = ~clk;
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic send(input logic [1:0] c);
		cmdValid = 1;
		cmdCode = c;
		cyc(1);
		cmdValid = 0;
	endtask
	// bounded wait for a completion result
	task automatic waitDone(input int lim, output int n);
		for (n = 0; n < lim && opcEvent !== 1'b1 && qValid !== 1'b1; n++) cyc(1);
		if (n == lim) begin
			n_errors++;
			finish_test();
		end
	endtask
	task automatic test_opc();
		measDisplayed = 8'h03;
		measOn = 8'h05;
		eventEnable = 8'h01;
		srqEnable = 8'h20;
		send(2'h0);
		cyc(10);
		chk("measReq", 1, measReq);
		measDone = 8'h01;
		cyc(1);
		measDone = 8'h00;
		waitDone(40, k);
		chk("settle", 1, 11 + k >= SC);
		chk("opcEvent", 1, opcEvent);
		chk("srqOpc", 1, srq);
		esrClear = 1;
		cyc(1);
		esrClear = 0;
		eventEnable = 8'h00;
		cyc(1);
		chk("opcClr", 0, opcEvent);
	endtask
	task automatic test_qry();
		srqEnable = 8'h00;
		prevDone = 0;
		measDone = 8'h01;
		send(2'h1);
		cyc(30);
		chk("hold", 1, holdOff);
		chk("early", 0, qValid);
		prevDone = 1;
		waitDone(5, k);
		chk("qData", 8'h31, qData);
		chk("mav", 1, mav);
		chk("holdRel", 0, holdOff);
		chk("noSrq", 0, srq);
		srqEnable = 8'h10;
		cyc(1);
		chk("srqMav", 1, srq);
		rdEn = 1;
		cyc(3);
		rdEn = 0;
		chk("got", 8'h31, got);
		chk("mavClr", 0, mav);
	endtask
	task automatic test_wai();
		measDisplayed = 8'h04;
		measOn = 8'h04;
		measDone = 8'h00;
		send(2'h2);
		cyc(60);
		chk("stall", 1, cmdStall);
		chk("never", 1, busy);
		send(2'h0);
		abort = 1;
		cyc(1);
		abort = 0;
		cyc(2);
		chk("abort", 0, cmdStall);
		chk("ignored", 0, opcEvent);
		send(2'h3);
		cyc(2);
		chk("plainBusy", 1, busy);
		chk("plainStall", 0, cmdStall);
		abort = 1;
		cyc(1);
		abort = 0;
		cyc(1);
		chk("abort2", 0, busy);
	endtask
	initial begin
		cyc(2);
		rstn = 1;
		chk("rst", 0, {busy, qValid, opcEvent, mav, srq, holdOff, cmdStall, measReq});
		test_opc();
		test_qry();
		test_wai();
		finish_test();
	end
endmodule
